// file: verilog/twowire_pkg.sv
`default_nettype none
package twowire_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_OWN    = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DATA   = 8'h0c;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int         SLA_MSB          = 7;
   localparam int         SLA_LSB          = 1;
   localparam int         GCE_BIT          = 0;
   localparam int         CODE_LSB         = 3;
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
   localparam logic [2:0] LAST_BIT         = 3'h7;
   localparam logic [7:0] OWN_RESET        = 8'h00;
   localparam logic [7:0] DATA_RESET       = 8'hff;
   localparam logic [1:0] PRESCALER_RESET  = 2'h0;

   typedef struct packed {
      logic flag;
      logic ack_enable;
      logic start_request;
      logic stop_request;
      logic write_collision_flag;
      logic interface_enable;
      logic reserved;
      logic serial_irq_enable;
   } twowire_control_t;

   localparam twowire_control_t CTRL_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Status codes, prescaler bits excluded
   // ---------------------------------------------------------------
   localparam logic [7:0] STATUS_OWN_READ   = 8'ha8;
   localparam logic [7:0] STATUS_ARB_READ   = 8'hb0;
   localparam logic [7:0] STATUS_DATA_ACK   = 8'hb8;
   localparam logic [7:0] STATUS_DATA_NACK  = 8'hc0;
   localparam logic [7:0] STATUS_LAST_ACK   = 8'hc8;
   localparam logic [7:0] STATUS_NO_INFO    = 8'hf8;
   localparam logic [7:0] STATUS_BUS_ERROR  = 8'h00;

   // ---------------------------------------------------------------
   // AHB-Lite encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [2:0] {
      LINK_IDLE      = 3'b000,
      LINK_ADDR      = 3'b001,
      LINK_ADDR_LAST = 3'b010,
      LINK_ADDR_ACK  = 3'b011,
      LINK_HOLD      = 3'b100,
      LINK_TX        = 3'b101,
      LINK_ACK_CHECK = 3'b110,
      LINK_BUS_ERROR = 3'b111
   } link_state_t;

endpackage
`default_nettype wire

// file: verilog/twowire_slave_transmitter.sv
`default_nettype none
module twowire_slave_transmitter (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output var  logic [31:0] hrdata_out,
   output      logic        hreadyout_out,
   output      logic        hresp_out,
   // Two-wire bus pins, open drain
   input  wire logic        scl_in,
   output      logic        scl_out,
   output      logic        scl_oe_out,
   input  wire logic        sda_in,
   output      logic        sda_out,
   output      logic        sda_oe_out,
   // System sideband
   input  wire logic        sleep_in,
   input  wire logic        arb_lost_in,
   output var  logic        wake_request_out,
   output      logic        start_pending_out,
   output var  logic        slave_receive_out
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]                    own_slave_address;
   twowire_pkg::twowire_control_t twowire_control;
   logic [7:0]                    status_code;
   logic [1:0]                    prescaler;
   logic [7:0]                    twowire_data_reg;

   twowire_pkg::link_state_t      state, next_state;
   logic [2:0]                    bit_count, next_bit_count;
   logic [7:0]                    shift, next_shift;
   logic                          ack_seen, next_ack_seen;
   logic                          last_byte, next_last_byte;
   logic                          tx_setup, arb_flag, bus_busy;
   logic [7:0]                    next_status;
   logic                          flag_set, stop_clear, addr_capture;
   logic                          match_event, receive_event;
   logic                          wr_pending;
   logic [7:0]                    wr_addr;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic scl_meta, scl_sync, scl_prev;
   logic sda_meta, sda_sync, sda_prev;

   always_ff @(posedge mclk_in) begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
   end

   wire scl_rise   = scl_sync & ~scl_prev;
   wire scl_fall   = ~scl_sync & scl_prev;
   wire start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
   wire stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

   // ---------------------------------------------------------------
   // AHB-Lite decode
   // ---------------------------------------------------------------
   wire addr_phase = hsel_in & hready_in & (htrans_in == twowire_pkg::HTRANS_NONSEQ);
   wire [7:0] req_addr = haddr_in[7:0];
   wire       req_low  = (haddr_in[31:8] == 24'h000000);
   wire [7:0] wbyte     = hwdata_in[7:0];
   wire       wr_own    = wr_pending & (wr_addr == twowire_pkg::ADDR_OWN);
   wire       wr_ctrl   = wr_pending & (wr_addr == twowire_pkg::ADDR_CTRL);
   wire       wr_status = wr_pending & (wr_addr == twowire_pkg::ADDR_STATUS);
   wire       wr_data   = wr_pending & (wr_addr == twowire_pkg::ADDR_DATA);
   twowire_pkg::twowire_control_t wctrl;
   assign wctrl = wbyte;
   wire flag_clear = wr_ctrl & wctrl.flag;

   // Flag low hides the code behind the no-information value
   wire [7:0] status_view = twowire_control.flag ? status_code : twowire_pkg::STATUS_NO_INFO;
   wire [7:0] status_read = {status_view[7:twowire_pkg::CODE_LSB], 1'b0, prescaler};

   wire [7:0] read_byte =
      (req_addr == twowire_pkg::ADDR_OWN)    ? own_slave_address :
      (req_addr == twowire_pkg::ADDR_CTRL)   ? twowire_control   :
      (req_addr == twowire_pkg::ADDR_STATUS) ? status_read       :
      (req_addr == twowire_pkg::ADDR_DATA)   ? twowire_data_reg  : 8'h00;

   assign hreadyout_out = 1'b1;
   assign hresp_out     = twowire_pkg::HRESP_OKAY;

   // Read data is fetched at the address phase so it stands registered
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         wr_pending <= 1'b0;
         wr_addr    <= 8'h00;
         hrdata_out <= 32'h00000000;
      end else begin
         wr_pending <= addr_phase & hwrite_in & req_low;
         wr_addr    <= req_addr;
         if (addr_phase & ~hwrite_in) begin
            hrdata_out <= {24'h000000, req_low ? read_byte : 8'h00};
         end
      end
   end

   // ---------------------------------------------------------------
   // Address recognition
   // ---------------------------------------------------------------
   wire [7:0] addr_byte = {shift[6:0], sda_sync};
   wire own_hit = addr_byte[7:1] == own_slave_address[twowire_pkg::SLA_MSB:twowire_pkg::SLA_LSB];
   wire gc_hit  = (addr_byte[7:1] == twowire_pkg::GENERAL_CALL_ADDR)
                  & own_slave_address[twowire_pkg::GCE_BIT];
   wire addr_match = twowire_control.ack_enable & (own_hit | gc_hit);
   wire read_dir   = addr_byte[0];
   wire done_code  = (status_code == twowire_pkg::STATUS_DATA_NACK) |
                     (status_code == twowire_pkg::STATUS_LAST_ACK);
   wire addressed  = (state == twowire_pkg::LINK_ADDR_LAST) |
                     (state == twowire_pkg::LINK_ADDR_ACK) |
                     (state == twowire_pkg::LINK_TX) |
                     (state == twowire_pkg::LINK_ACK_CHECK);
   wire bus_error  = addressed & (start_cond | stop_cond);

   // ---------------------------------------------------------------
   // Link state machine
   // ---------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_bit_count = bit_count;
      next_shift     = shift;
      next_ack_seen  = ack_seen;
      next_last_byte = last_byte;
      next_status    = status_code;
      flag_set       = 1'b0;
      stop_clear     = 1'b0;
      addr_capture   = 1'b0;
      match_event    = 1'b0;
      receive_event  = 1'b0;
      if (bus_error) begin
         next_state  = twowire_pkg::LINK_BUS_ERROR;
         next_status = twowire_pkg::STATUS_BUS_ERROR;
         flag_set    = 1'b1;
      end else begin
         unique case (state)
            twowire_pkg::LINK_IDLE: begin
               // Bus is watched even with acknowledge disabled
               if (start_cond) begin
                  next_state     = twowire_pkg::LINK_ADDR;
                  next_bit_count = 3'h0;
               end
            end
            twowire_pkg::LINK_ADDR: begin
               if (stop_cond) begin
                  next_state = twowire_pkg::LINK_IDLE;
               end else if (start_cond) begin
                  next_bit_count = 3'h0;
               end else if (scl_rise) begin
                  next_shift     = addr_byte;
                  next_bit_count = bit_count + 3'h1;
                  if (bit_count == twowire_pkg::LAST_BIT) begin
                     addr_capture = addr_match;
                     if (addr_match & read_dir) begin
                        next_state  = twowire_pkg::LINK_ADDR_LAST;
                        match_event = 1'b1;
                     end else begin
                        receive_event = addr_match;
                        next_state    = twowire_pkg::LINK_IDLE;
                     end
                  end
               end
            end
            twowire_pkg::LINK_ADDR_LAST: begin
               if (scl_fall) begin
                  next_state = twowire_pkg::LINK_ADDR_ACK;
               end
            end
            twowire_pkg::LINK_ADDR_ACK: begin
               if (scl_fall) begin
                  next_state  = twowire_pkg::LINK_HOLD;
                  flag_set    = 1'b1;
                  next_status = arb_flag ? twowire_pkg::STATUS_ARB_READ
                                         : twowire_pkg::STATUS_OWN_READ;
               end
            end
            twowire_pkg::LINK_HOLD: begin
               if (~twowire_control.flag) begin
                  if (done_code) begin
                     next_state = twowire_pkg::LINK_IDLE;
                  end else begin
                     next_state     = twowire_pkg::LINK_TX;
                     next_shift     = twowire_data_reg;
                     next_bit_count = 3'h0;
                     next_last_byte = ~twowire_control.ack_enable;
                  end
               end
            end
            twowire_pkg::LINK_TX: begin
               if (scl_fall) begin
                  next_bit_count = bit_count + 3'h1;
                  next_shift     = {shift[6:0], 1'b1};
                  if (bit_count == twowire_pkg::LAST_BIT) begin
                     next_state = twowire_pkg::LINK_ACK_CHECK;
                  end
               end
            end
            twowire_pkg::LINK_ACK_CHECK: begin
               if (scl_rise) begin
                  next_ack_seen = ~sda_sync;
               end else if (scl_fall) begin
                  next_state = twowire_pkg::LINK_HOLD;
                  flag_set   = 1'b1;
                  if (~ack_seen) begin
                     next_status = twowire_pkg::STATUS_DATA_NACK;
                  end else if (last_byte) begin
                     next_status = twowire_pkg::STATUS_LAST_ACK;
                  end else begin
                     next_status = twowire_pkg::STATUS_DATA_ACK;
                  end
               end
            end
            twowire_pkg::LINK_BUS_ERROR: begin
               if (flag_clear & wctrl.stop_request) begin
                  next_state = twowire_pkg::LINK_IDLE;
                  stop_clear = 1'b1;
               end
            end
         endcase
      end
      if (~twowire_control.interface_enable) begin
         next_state = twowire_pkg::LINK_IDLE;
         flag_set   = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state     <= twowire_pkg::LINK_IDLE;
         bit_count <= 3'h0;
         shift     <= 8'hff;
         ack_seen  <= 1'b0;
         last_byte <= 1'b0;
         tx_setup  <= 1'b0;
      end else begin
         state     <= next_state;
         bit_count <= next_bit_count;
         shift     <= next_shift;
         ack_seen  <= next_ack_seen;
         last_byte <= next_last_byte;
         tx_setup  <= (state == twowire_pkg::LINK_HOLD) & (next_state == twowire_pkg::LINK_TX);
      end
   end

   // ---------------------------------------------------------------
   // Bus tracking and sideband
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         bus_busy          <= 1'b0;
         arb_flag          <= 1'b0;
         wake_request_out  <= 1'b0;
         slave_receive_out <= 1'b0;
      end else begin
         bus_busy <= start_cond | (bus_busy & ~stop_cond);
         // Arrival wins over the consuming acknowledge
         if (arb_lost_in) begin
            arb_flag <= 1'b1;
         end else if (stop_cond | (flag_set & (state == twowire_pkg::LINK_ADDR_ACK))) begin
            arb_flag <= 1'b0;
         end
         // Leaving sleep drops the request
         wake_request_out <= sleep_in & (wake_request_out | match_event);
         slave_receive_out <= receive_event;
      end
   end

   // Master side launches the start; only asked for once the bus is free
   assign start_pending_out = twowire_control.start_request & ~bus_busy &
                              (state == twowire_pkg::LINK_IDLE);

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         own_slave_address <= twowire_pkg::OWN_RESET;
         twowire_control   <= twowire_pkg::CTRL_RESET;
         status_code       <= twowire_pkg::STATUS_NO_INFO;
         prescaler         <= twowire_pkg::PRESCALER_RESET;
         twowire_data_reg  <= twowire_pkg::DATA_RESET;
      end else begin
         status_code <= next_status;
         if (wr_own) begin
            own_slave_address <= wbyte;
         end
         if (wr_status) begin
            prescaler <= wbyte[1:0];
         end
         if (wr_ctrl) begin
            twowire_control.ack_enable        <= wctrl.ack_enable;
            twowire_control.start_request     <= wctrl.start_request;
            twowire_control.interface_enable  <= wctrl.interface_enable;
            twowire_control.serial_irq_enable <= wctrl.serial_irq_enable;
         end
         if (stop_clear) begin
            twowire_control.stop_request <= 1'b0;
         end else if (wr_ctrl) begin
            twowire_control.stop_request <= wctrl.stop_request;
         end
         // Set beats a clear that lands in the same cycle
         if (flag_set) begin
            twowire_control.flag <= 1'b1;
         end else if (flag_clear) begin
            twowire_control.flag <= 1'b0;
         end
         // Data is only taken while the flag stands
         if (wr_data) begin
            twowire_control.write_collision_flag <= ~twowire_control.flag;
            if (twowire_control.flag) begin
               twowire_data_reg <= wbyte;
            end
         end else if (addr_capture & ~sleep_in) begin
            // Asleep, the address byte never reaches the data register
            twowire_data_reg <= addr_byte;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drive: open drain, enable pulls low
   // ---------------------------------------------------------------
   assign scl_out    = 1'b0;
   assign sda_out    = 1'b0;
   // Holding low also covers a wake-up of any length
   assign scl_oe_out = (state == twowire_pkg::LINK_HOLD) | tx_setup;
   assign sda_oe_out = (state == twowire_pkg::LINK_ADDR_ACK) |
                       ((state == twowire_pkg::LINK_TX) & ~shift[7]);

endmodule
`default_nettype wire

// file: tb/twowire_slave_transmitter_assertions.sv
`default_nettype none
module twowire_slave_transmitter_checker (
   // Watched ports of the slave
   input wire logic        mclk_in,
   input wire logic        reset_in,
   input wire logic [31:0] hrdata_out,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic        scl_out,
   input wire logic        scl_oe_out,
   input wire logic        sda_out,
   input wire logic        sda_oe_out,
   input wire logic        sleep_in,
   input wire logic        wake_request_out,
   input wire logic        start_pending_out,
   input wire logic        slave_receive_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // -------------------------------------------------------------
   // Sequences and properties
   // -------------------------------------------------------------
   sequence s_pulse_once;
      slave_receive_out ##1 !slave_receive_out;
   endsequence
   sequence s_no_ack;
      !sda_oe_out [*2];
   endsequence
   a_reset_quiet: assert property ($fell(reset_in) |->
      !scl_oe_out && !sda_oe_out && !wake_request_out) else $error("lines driven after reset");
   a_bus_okay: assert property (hreadyout_out && hresp_out == twowire_pkg::HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_pins_low: assert property (!scl_out && !sda_out) else $error("pin driven high");
   a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0) else $error("upper read bits set");
   a_rx_pulse: assert property ($rose(slave_receive_out) |-> s_pulse_once and s_no_ack)
      else $error("receive match not a bare pulse");
   a_wake_clear: assert property (!sleep_in |=> !wake_request_out)
      else $error("wake request while awake");
   a_wake_hold: assert property ($rose(wake_request_out) |-> $past(sleep_in)
      ##[0:40] scl_oe_out) else $error("wake match without clock hold");
   a_start_quiet: assert property (start_pending_out |-> !scl_oe_out && !sda_oe_out)
      else $error("start pending while lines held");
endmodule
bind twowire_slave_transmitter twowire_slave_transmitter_checker chk_u (.*);
`default_nettype wire

// file: tb/twowire_bus_master.sv
`default_nettype none
module twowire_bus_master (
   // Clock and wire levels
   input  wire logic clk_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   // Pulls, high drives the line low
   output var  logic scl_oe_out = 1'b0,
   output var  logic sda_oe_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Four cycles per phase give the 80 ns bit; waits honour slave stretching
   task automatic start();
      @(posedge clk_in);
      sda_oe_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      scl_oe_out <= 1'b1;
   endtask
   task automatic bits(input logic [8:0] o, output logic [8:0] i);
      for (int k = 8; k >= 0; k--) begin
         @(posedge clk_in);
         sda_oe_out <= ~o[k];
         repeat (3) @(posedge clk_in);
         scl_oe_out <= 1'b0;
         do @(posedge clk_in); while (!scl_in);
         repeat (3) @(posedge clk_in);
         i[k] = sda_in;
         scl_oe_out <= 1'b1;
      end
   endtask
   task automatic stop();
      @(posedge clk_in);
      sda_oe_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      scl_oe_out <= 1'b0;
      do @(posedge clk_in); while (!scl_in);
      repeat (3) @(posedge clk_in);
      sda_oe_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// file: tb/test_twowire_slave_transmitter.sv
`default_nettype none
module test_twowire_slave_transmitter;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
   logic        mclk_in = 0, reset_in = 1, hsel_in = 0, hwrite_in = 0, sleep_in = 0;
   logic        arb_lost_in = 0, rx_seen = 0, m_scl, m_sda;
   logic [1:0]  htrans_in = 0;
   logic [2:0]  hsize_in = 3'h2;
   logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, r;
   logic        hreadyout_out, hresp_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
   logic        wake_request_out, start_pending_out, slave_receive_out;
   logic [8:0]  i;
   wire logic   hready_in, scl_in, sda_in;
   int          num_errors = 0, checks = 0;
   // Lines idle high through pull-ups whenever nobody pulls
   assign hready_in = hreadyout_out;
   assign scl_in = !(scl_oe_out | m_scl);
   assign sda_in = !(sda_oe_out | m_sda);
   row_t rows [16] = '{'{8'h00,1'b0,8'h00,8'h00}, '{8'h04,1'b0,8'h00,8'h00},
      '{8'h08,1'b0,8'h00,8'hf8}, '{8'h0c,1'b0,8'h00,8'hff}, '{8'h08,1'b1,8'h03,8'h00},
      '{8'h08,1'b0,8'h00,8'hfb}, '{8'h08,1'b1,8'h00,8'h00}, '{8'h00,1'b1,8'h54,8'h00},
      '{8'h00,1'b0,8'h00,8'h54}, '{8'h04,1'b1,8'h46,8'h00}, '{8'h04,1'b0,8'h00,8'h44},
      '{8'h0c,1'b1,8'h5a,8'h00}, '{8'h0c,1'b0,8'h00,8'hff}, '{8'h04,1'b0,8'h00,8'h4c},
      '{8'h10,1'b1,8'h12,8'h00}, '{8'h10,1'b0,8'h00,8'h00}};
   twowire_slave_transmitter dut_u (.*);
   twowire_bus_master pm_u (.clk_in(mclk_in), .scl_in(scl_in), .sda_in(sda_in),
      .scl_oe_out(m_scl), .sda_oe_out(m_sda));
   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (slave_receive_out) rx_seen <= 1'b1;
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk_in);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, a};
      htrans_in <= twowire_pkg::HTRANS_NONSEQ;
      hwrite_in <= w;
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= {24'h0, d};
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      r = hrdata_out;
   endtask
   task automatic st(input logic [7:0] e);
      // Link events reach the flag a few cycles after the pin edge
      repeat (6) @(posedge mclk_in);
      bus(twowire_pkg::ADDR_STATUS, 1'b0, 8'h00);
      chk(r & 32'hf8, {24'h0, e});
   endtask
   task automatic rd(input logic [7:0] d, input logic [7:0] c, input logic ak,
                     input logic [7:0] e);
      bus(twowire_pkg::ADDR_DATA, 1'b1, d);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, c);
      pm_u.bits({8'hff, ak}, i);
      chk({24'h0, i[8:1]}, {24'h0, d});
      st(e);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk_in);
      reset_in <= 1'b0;
      foreach (rows[n]) begin
         bus(rows[n].a, rows[n].w, rows[n].d);
         if (!rows[n].w) chk(r, {24'h0, rows[n].e});
      end
      $display("register table done");
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'h44);
      pm_u.start();
      pm_u.bits(9'h0ab, i);
      chk(i[0], 0);
      repeat (6) @(posedge mclk_in);
      chk(scl_oe_out, 1);
      st(8'ha8);
      rd(8'ha5, 8'hc4, 1'b0, 8'hb8);
      rd(8'h3c, 8'h84, 1'b0, 8'hc8);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'h84);
      pm_u.bits(9'h1ff, i);
      chk(i[8:1], 8'hff);
      pm_u.stop();
      pm_u.start();
      pm_u.bits(9'h0ab, i);
      chk(i[0], 1);
      st(8'hf8);
      pm_u.stop();
      $display("read transfer and silent slave done");
      bus(twowire_pkg::ADDR_OWN, 1'b1, 8'h55);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'h44);
      sleep_in <= 1'b1;
      pm_u.start();
      pm_u.bits(9'h003, i);
      chk(i[0], 0);
      repeat (6) @(posedge mclk_in);
      chk(wake_request_out, 1);
      chk(scl_oe_out, 1);
      st(8'ha8);
      sleep_in <= 1'b0;
      rd(8'h81, 8'hc4, 1'b1, 8'hc0);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'hc4);
      pm_u.stop();
      pm_u.start();
      pm_u.bits(9'h0a9, i);
      chk(i[0], 1);
      chk(rx_seen, 1);
      pm_u.stop();
      $display("general call wake and write match done");
      arb_lost_in <= 1'b1;
      @(posedge mclk_in);
      arb_lost_in <= 1'b0;
      pm_u.start();
      pm_u.bits(9'h0ab, i);
      st(8'hb0);
      rd(8'h77, 8'hc4, 1'b1, 8'hc0);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'hc4);
      pm_u.stop();
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'h64);
      @(posedge mclk_in);
      chk(start_pending_out, 1);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'h44);
      $display("lost arbitration and start request done");
      // Stop in mid byte is a bus error; then reset while the clock is held
      pm_u.start();
      pm_u.bits(9'h0ab, i);
      st(8'ha8);
      bus(twowire_pkg::ADDR_DATA, 1'b1, 8'hff);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'hc4);
      pm_u.stop();
      st(8'h00);
      chk({scl_oe_out, sda_oe_out}, 0);
      bus(twowire_pkg::ADDR_CTRL, 1'b1, 8'hd4);
      bus(twowire_pkg::ADDR_CTRL, 1'b0, 8'h00);
      chk(r, 32'h44);
      pm_u.start();
      pm_u.bits(9'h0ab, i);
      st(8'ha8);
      reset_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      reset_in <= 1'b0;
      @(posedge mclk_in);
      chk(scl_oe_out, 0);
      bus(twowire_pkg::ADDR_CTRL, 1'b0, 8'h00);
      chk(r, 0);
      pm_u.stop();
      $display("bus error and reset done");
      test_done();
   end
   // Whole run is about twelve hundred cycles; this bounds a stuck wait
   initial begin
      #300000;
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
